// ===== hw/udrs_regs.vh
// Purpose: constants for the dual role port switch
// Assumes: plain Verilog-2005, included by bare name
// Notes:   role sense level encodings and owner codes
`ifndef UDRS_REGS_VH
`define UDRS_REGS_VH

// role sense level that hands the ports to the device controller
`define UDRS_ROLE_DEVICE     1'h1
// role sense level that hands the ports to the host controller
`define UDRS_ROLE_HOST       1'h0
// owner after reset: host controller
`define UDRS_OWNER_RESET     1'h0
// synchroniser reset value, matching the host role
`define UDRS_SYNC_RESET      2'h0
// receiver detection value meaning nothing is attached
`define UDRS_RXDET_NONE      1'h0
// receive level shown to the side that does not own the port
`define UDRS_RX_IDLE         1'h0

`endif

// ===== hw/udrs_port_switch.v
// Purpose: hands one shared high speed port and one shared superspeed port
//          to either the host controller or the device controller
// Assumes: single 25 MHz clock, asynchronous active high reset, role sense pin
//          is asynchronous to the clock
// Notes:   analog pad routing is modelled as per-signal digital steering
//          the owner flag lags the pin by three edges; pulses shorter
//          than a clock may be missed and leave the owner unchanged
//          while the device holds the ports the host only ever sees quiet
//          receive lines and a receiver detect of no partner
//          after reset the host owns both ports until the pin is sampled
// Notes on behaviour
// RULE1: both shared ports belong to exactly one owner at any time, host or device.
// RULE2: a high role sense level gives both shared ports to the device controller.
// RULE3: a low role sense level gives both shared ports to the host controller.
// RULE4: while the device owns the ports the host sees its receiver detect as disconnected.
// RULE5: the role sense pin is synchronised so both ports switch together on one edge.
`timescale 1ns/1ns
`include "udrs_regs.vh"

module udrs_port_switch
(
    input  wire clock_i,
    input  wire rst_i,
    input  wire port_role_sense_i,
    // high speed pair, pad side (two-way: in, out, enable per line)
    input  wire shared_hs_port_pos_i,
    output wire shared_hs_port_pos_o,
    output wire shared_hs_port_pos_oe_o,
    input  wire shared_hs_port_neg_i,
    output wire shared_hs_port_neg_o,
    output wire shared_hs_port_neg_oe_o,
    // superspeed pad side
    input  wire shared_ss_port_rx_pos_i,
    output wire shared_ss_port_tx_pos_o,
    input  wire shared_ss_port_rxdet_i,
    // host controller side
    input  wire host_hs_pos_i,
    input  wire host_hs_pos_oe_i,
    input  wire host_hs_neg_i,
    input  wire host_hs_neg_oe_i,
    input  wire host_ss_tx_pos_i,
    output wire host_hs_pos_o,
    output wire host_hs_neg_o,
    output wire host_ss_rx_pos_o,
    output wire host_ss_rxdet_o,
    // device controller side
    input  wire dev_hs_pos_i,
    input  wire dev_hs_pos_oe_i,
    input  wire dev_hs_neg_i,
    input  wire dev_hs_neg_oe_i,
    input  wire dev_ss_tx_pos_i,
    output wire dev_hs_pos_o,
    output wire dev_hs_neg_o,
    output wire dev_ss_rx_pos_o,
    output wire dev_ss_rxdet_o,
    // current owner: high means device controller
    output wire owner_is_device_o
);

    reg  [1:0] role_sync_ff;
    reg        owner_dev_ff;
    wire       nxt_owner_dev;

    // steered levels, settled in combinational processes before the ports
    reg        pad_hs_pos_drv;
    reg        pad_hs_pos_en;
    reg        pad_hs_neg_drv;
    reg        pad_hs_neg_en;
    reg        pad_ss_tx_drv;
    reg        host_hs_pos_rx;
    reg        host_hs_neg_rx;
    reg        host_ss_rxd;
    reg        host_ss_det;
    reg        dev_hs_pos_rx;
    reg        dev_hs_neg_rx;
    reg        dev_ss_rxd;
    reg        dev_ss_det;

    // pick the owner's level for a line that leaves through a shared pad;
    // one select input for every line keeps the two ports from splitting
    function udrs_pick;
        input owner_dev;
        input dev_level;
        input host_level;
        begin
            if (owner_dev)
            begin
                udrs_pick = dev_level;
            end
            else
            begin
                udrs_pick = host_level;
            end
        end
    endfunction

    // hand a received pad level to one side only while that side owns the
    // port; the side that does not own it sees the quiet level instead
    function udrs_gate;
        input side_owns;
        input pad_level;
        input quiet_level;
        begin
            if (side_owns)
            begin
                udrs_gate = pad_level;
            end
            else
            begin
                udrs_gate = quiet_level;
            end
        end
    endfunction

    // two-stage synchroniser on the role sense pin
    // only the second stage feeds logic, the first may still be settling
    always @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            role_sync_ff <= `UDRS_SYNC_RESET;
        end
        else
        begin
            role_sync_ff <= {role_sync_ff[0], port_role_sense_i}; // RULE5
        end
    end

    // owner decision from the synchronised level only
    assign nxt_owner_dev = (role_sync_ff[1] == `UDRS_ROLE_DEVICE); // RULE2 RULE3

    // single owner flop steers both ports, so they never split
    // a change lands on one edge for every steered line at once
    always @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            owner_dev_ff <= `UDRS_OWNER_RESET;
        end
        else
        begin
            owner_dev_ff <= nxt_owner_dev; // RULE1 RULE5
        end
    end

    // owner flag, straight from the flop
    assign owner_is_device_o = owner_dev_ff;

    // high speed positive line: level and enable follow the owner together
    always @*
    begin
        pad_hs_pos_drv = udrs_pick(owner_dev_ff, dev_hs_pos_i, host_hs_pos_i); // RULE1
        pad_hs_pos_en  = udrs_pick(owner_dev_ff, dev_hs_pos_oe_i, host_hs_pos_oe_i);
    end

    // high speed negative line: level and enable follow the owner together
    always @*
    begin
        pad_hs_neg_drv = udrs_pick(owner_dev_ff, dev_hs_neg_i, host_hs_neg_i); // RULE1
        pad_hs_neg_en  = udrs_pick(owner_dev_ff, dev_hs_neg_oe_i, host_hs_neg_oe_i);
    end

    // superspeed transmit line from the owner only
    always @*
    begin
        pad_ss_tx_drv = udrs_pick(owner_dev_ff, dev_ss_tx_pos_i, host_ss_tx_pos_i); // RULE1
    end

    // high speed receive toward the host, quiet while the device owns
    always @*
    begin
        host_hs_pos_rx = udrs_gate(!owner_dev_ff, shared_hs_port_pos_i, `UDRS_RX_IDLE); // RULE1
        host_hs_neg_rx = udrs_gate(!owner_dev_ff, shared_hs_port_neg_i, `UDRS_RX_IDLE);
    end

    // superspeed receive toward the host, quiet while the device owns
    always @*
    begin
        host_ss_rxd = udrs_gate(!owner_dev_ff, shared_ss_port_rx_pos_i, `UDRS_RX_IDLE);
    end

    // host receiver detect: no partner while the device owns, so no enumeration
    always @*
    begin
        host_ss_det = udrs_gate(!owner_dev_ff, shared_ss_port_rxdet_i, `UDRS_RXDET_NONE); // RULE4
    end

    // high speed receive toward the device, quiet while the host owns
    always @*
    begin
        dev_hs_pos_rx = udrs_gate(owner_dev_ff, shared_hs_port_pos_i, `UDRS_RX_IDLE); // RULE1
        dev_hs_neg_rx = udrs_gate(owner_dev_ff, shared_hs_port_neg_i, `UDRS_RX_IDLE);
    end

    // superspeed receive toward the device, quiet while the host owns
    always @*
    begin
        dev_ss_rxd = udrs_gate(owner_dev_ff, shared_ss_port_rx_pos_i, `UDRS_RX_IDLE);
    end

    // device receiver detect, shown only while the device owns
    always @*
    begin
        dev_ss_det = udrs_gate(owner_dev_ff, shared_ss_port_rxdet_i, `UDRS_RXDET_NONE);
    end

    // pad side outputs
    assign shared_hs_port_pos_o    = pad_hs_pos_drv;
    assign shared_hs_port_pos_oe_o = pad_hs_pos_en;
    assign shared_hs_port_neg_o    = pad_hs_neg_drv;
    assign shared_hs_port_neg_oe_o = pad_hs_neg_en;
    assign shared_ss_port_tx_pos_o = pad_ss_tx_drv;

    // host controller side outputs
    assign host_hs_pos_o    = host_hs_pos_rx;
    assign host_hs_neg_o    = host_hs_neg_rx;
    assign host_ss_rx_pos_o = host_ss_rxd;
    assign host_ss_rxdet_o  = host_ss_det;

    // device controller side outputs
    assign dev_hs_pos_o     = dev_hs_pos_rx;
    assign dev_hs_neg_o     = dev_hs_neg_rx;
    assign dev_ss_rx_pos_o  = dev_ss_rxd;
    assign dev_ss_rxdet_o   = dev_ss_det;

endmodule

// ===== testbench/udrs_port_switch_properties.sv
// Purpose: ownership checks for the port switch
// Assumes: sees the switch ports only
// Notes:   owner lags a steady pin by three edges
`timescale 1ns/1ns
module udrs_chk(input wire clock_i, rst_i, port_role_sense_i, owner_is_device_o,
    host_ss_rxdet_o, shared_ss_port_tx_pos_o, host_ss_tx_pos_i, dev_ss_tx_pos_i);
    wire p = port_role_sense_i, o = owner_is_device_o;
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // owner against the pin, rx detect masking and transmit steering
    a_dev_on_high: assert property (p [*3] |=> o) else $error("no device");
    a_host_on_low: assert property ((!p) [*3] |=> !o) else $error("no host");
    a_rxdet_off: assert property (o |-> !host_ss_rxdet_o) else $error("rxdet");
    a_one_owner: assert property (shared_ss_port_tx_pos_o ==
        (o ? dev_ss_tx_pos_i : host_ss_tx_pos_i)) else $error("split");
    a_sync_lag: assert property ($changed(o) |-> o == $past(p, 3)) else $error("lag");
    c_dev: cover property ($rose(o));
    c_host: cover property ($fell(o));
    c_mask: cover property (o && host_ss_tx_pos_i);
endmodule
bind udrs_port_switch udrs_chk u_chk(.*);

// ===== testbench/udrs_ctrl_model.sv
// Purpose: host and device controller drive model
// Assumes: both controllers drive every cycle
// Notes:   device drives the inverse so a wrong select shows
`timescale 1ns/1ns
module udrs_ctrl_model(input wire clock_i, output logic [4:0] host_o = 5'h0, dev_o);
    // running pattern on host, inverse on device
    always @(posedge clock_i) host_o <= host_o + 5'h1;
    assign dev_o = ~host_o;
endmodule

// ===== testbench/udrs_port_switch_tb.sv
// Purpose: self-checking bench for the port switch
// Assumes: inputs move 1 ns after a rising edge
// Notes:   unowned receive outputs sit at 0
`timescale 1ns/1ns
module udrs_port_switch_tb;
    logic       clock_i = 1'b0, rst_i = 1'b1, pin = 1'b0;
    logic [3:0] pd = 4'h9;
    wire  [4:0] hv, dv, po;
    wire  [3:0] ho, dvo;
    wire        own;
    int         n_mismatch = 0, samples_checked = 0, cyc = 0;
    udrs_ctrl_model ctl(.clock_i(clock_i), .host_o(hv), .dev_o(dv));
    udrs_port_switch dut(.clock_i(clock_i), .rst_i(rst_i), .port_role_sense_i(pin),
        .shared_hs_port_pos_i(pd[0]), .shared_ss_port_rx_pos_i(pd[1]),
        .shared_hs_port_neg_i(pd[2]), .shared_ss_port_rxdet_i(pd[3]),
        .shared_hs_port_pos_o(po[0]), .shared_hs_port_pos_oe_o(po[1]),
        .shared_hs_port_neg_o(po[2]), .shared_hs_port_neg_oe_o(po[3]),
        .shared_ss_port_tx_pos_o(po[4]), .host_hs_pos_i(hv[0]), .host_hs_pos_oe_i(hv[1]),
        .host_hs_neg_i(hv[2]), .host_hs_neg_oe_i(hv[3]), .host_ss_tx_pos_i(hv[4]),
        .dev_hs_pos_i(dv[0]), .dev_hs_pos_oe_i(dv[1]), .dev_hs_neg_i(dv[2]),
        .dev_hs_neg_oe_i(dv[3]), .dev_ss_tx_pos_i(dv[4]), .host_hs_pos_o(ho[0]),
        .host_ss_rx_pos_o(ho[1]), .host_hs_neg_o(ho[2]), .host_ss_rxdet_o(ho[3]),
        .dev_hs_pos_o(dvo[0]), .dev_ss_rx_pos_o(dvo[1]), .dev_hs_neg_o(dvo[2]),
        .dev_ss_rxdet_o(dvo[3]), .owner_is_device_o(own));
    // clock and hang guard
    always #20 clock_i = ~clock_i;
    always @(posedge clock_i)
    begin
        cyc = cyc + 1;
        if (cyc == 400) begin n_mismatch++; end_sim; end
    end
    task chk(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'b1) begin n_mismatch++; $display("[ERR] %0t %s", $time, m); end
    endtask
    // move the pin and pad levels, then watch the hand over edge and every steered path
    task set_role(input logic v, input logic [3:0] pat);
        @(posedge clock_i) #1 pin = v;
        pd = pat;
        repeat (2) @(posedge clock_i);
        #1 chk(own === !v, "owner moved early");
        chk(po === (v ? hv : dv) && ho === (v ? pd : 4'h0), "split early");
        chk(dvo === (v ? 4'h0 : pd), "device early");
        @(posedge clock_i) #1 chk(own === v, "owner late");
        chk(po === (v ? dv : hv), "pad drive");
        chk(ho === (v ? 4'h0 : pd), "host receive");
        chk(dvo === (v ? pd : 4'h0), "device receive");
    endtask
    task end_sim;
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // reset, three hand overs, then a reset while the device owns the ports
    initial
    begin
        repeat (12) @(posedge clock_i);
        #1 rst_i = 1'b0;
        set_role(1'b1, 4'h9);
        set_role(1'b0, 4'h6);
        set_role(1'b1, 4'hE);
        rst_i = 1'b1;
        #1 chk(own === 1'b0, "reset owner");
        chk(po === hv && dvo === 4'h0, "reset paths");
        @(posedge clock_i) #1 rst_i = 1'b0;
        repeat (2) @(posedge clock_i) #1 chk(own === 1'b0, "early after reset");
        @(posedge clock_i) #1 chk(own === 1'b1 && po === dv, "owner after reset");
        chk(ho === 4'h0 && dvo === pd, "receive after reset");
        end_sim;
    end
endmodule
